/* File: hw/rsa_alu_map.vh */
`ifndef RSA_ALU_MAP_VH
`define RSA_ALU_MAP_VH
// operation codes
`define RSA_OP_NONE 5'h00
`define RSA_OP_ROT_LEFT_C 5'h01
`define RSA_OP_ROT_LEFT_C_WORK 5'h02
`define RSA_OP_ROT_RIGHT 5'h03
`define RSA_OP_ROT_RIGHT_WORK 5'h04
`define RSA_OP_ROT_RIGHT_C 5'h05
`define RSA_OP_ROT_RIGHT_C_WORK 5'h06
`define RSA_OP_DIFF_BORROW 5'h07
`define RSA_OP_DIFF_BORROW_MEM 5'h08
`define RSA_OP_SUB 5'h09
`define RSA_OP_DIFF_MEM 5'h0A
`define RSA_OP_SUBI 5'h0B
`define RSA_OP_DSZ 5'h0C
`define RSA_OP_DSZA 5'h0D
`define RSA_OP_ISZ 5'h0E
`define RSA_OP_ISZA 5'h0F
`define RSA_OP_BTS 5'h10
`define RSA_OP_SETB 5'h11
`define RSA_OP_SETBIT 5'h12
`define RSA_OP_NIB 5'h13
`define RSA_OP_NIBA 5'h14
// reset values and the all-ones byte
`define RSA_WORK_RST 8'h00
`define RSA_FLAG_RST 1'b0
`define RSA_WDATA_RST 8'h00
`define RSA_ALL_ONES 8'hFF
`endif

/* File: hw/rsa_alu.v */
`timescale 1ns/1ps
`include "rsa_alu_map.vh"

module rsa_alu (
  input wire clk_sys,
  input wire rstn,
  input wire exec_valid,
  input wire [4:0] exec_op,
  input wire [7:0] mem_rdata,
  input wire [7:0] imm_data,
  input wire [2:0] bit_sel,
  output reg [7:0] working_register,
  output reg flag_c,
  output reg flag_ac,
  output reg flag_z,
  output reg flag_ov,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  output reg skip_discard,
  output reg busy
);

  // ----------------------------------------
  // combinational result
  // ----------------------------------------
  reg [7:0] res;
  reg [7:0] sub_b;
  reg sub_cin;
  reg to_mem;
  reg to_work;
  reg set_c;
  reg next_c;
  reg arith;
  reg skip_hit;
  reg [4:0] low_sum;
  reg [8:0] full_sum;
  reg [7:0] bit_mask;

  // one op decode; flags only move where the op says so
  always @* begin
    res = mem_rdata;
    sub_b = ~mem_rdata;
    sub_cin = 1'b1;
    to_mem = 1'b0;
    to_work = 1'b0;
    set_c = 1'b0;
    next_c = flag_c;
    arith = 1'b0;
    skip_hit = 1'b0;
    bit_mask = 8'h01 << bit_sel;
    // borrow ops feed the carry in; every other subtract adds one
    if (exec_op == `RSA_OP_DIFF_BORROW || exec_op == `RSA_OP_DIFF_BORROW_MEM) begin
      sub_cin = flag_c;
    end
    if (exec_op == `RSA_OP_SUBI) begin
      sub_b = ~imm_data;
    end
    // the low nibble sum alone yields the carry out of bit 3
    low_sum = {1'b0, working_register[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_cin};
    full_sum = {1'b0, working_register} + {1'b0, sub_b} + {8'h00, sub_cin};
    case (exec_op)
      `RSA_OP_ROT_LEFT_C: begin
        res = {mem_rdata[6:0], flag_c};
        next_c = mem_rdata[7];
        set_c = 1'b1;
        to_mem = 1'b1;
      end
      `RSA_OP_ROT_LEFT_C_WORK: begin
        res = {mem_rdata[6:0], flag_c};
        next_c = mem_rdata[7];
        set_c = 1'b1;
        to_work = 1'b1;
      end
      `RSA_OP_ROT_RIGHT: begin
        res = {mem_rdata[0], mem_rdata[7:1]};
        to_mem = 1'b1;
      end
      `RSA_OP_ROT_RIGHT_WORK: begin
        res = {mem_rdata[0], mem_rdata[7:1]};
        to_work = 1'b1;
      end
      `RSA_OP_ROT_RIGHT_C: begin
        res = {flag_c, mem_rdata[7:1]};
        next_c = mem_rdata[0];
        set_c = 1'b1;
        to_mem = 1'b1;
      end
      `RSA_OP_ROT_RIGHT_C_WORK: begin
        res = {flag_c, mem_rdata[7:1]};
        next_c = mem_rdata[0];
        set_c = 1'b1;
        to_work = 1'b1;
      end
      `RSA_OP_DIFF_BORROW: begin
        res = full_sum[7:0];
        arith = 1'b1;
        to_work = 1'b1;
      end
      `RSA_OP_DIFF_BORROW_MEM: begin
        res = full_sum[7:0];
        arith = 1'b1;
        to_mem = 1'b1;
      end
      `RSA_OP_SUB: begin
        res = full_sum[7:0];
        arith = 1'b1;
        to_work = 1'b1;
      end
      `RSA_OP_DIFF_MEM: begin
        res = full_sum[7:0];
        arith = 1'b1;
        to_mem = 1'b1;
      end
      `RSA_OP_SUBI: begin
        res = full_sum[7:0];
        arith = 1'b1;
        to_work = 1'b1;
      end
      `RSA_OP_DSZ: begin
        res = mem_rdata - 8'h01;
        skip_hit = (res == 8'h00);
        to_mem = 1'b1;
      end
      `RSA_OP_DSZA: begin
        res = mem_rdata - 8'h01;
        skip_hit = (res == 8'h00);
        to_work = 1'b1;
      end
      `RSA_OP_ISZ: begin
        res = mem_rdata + 8'h01;
        skip_hit = (res == 8'h00);
        to_mem = 1'b1;
      end
      `RSA_OP_ISZA: begin
        res = mem_rdata + 8'h01;
        skip_hit = (res == 8'h00);
        to_work = 1'b1;
      end
      `RSA_OP_BTS: begin
        skip_hit = |(mem_rdata & bit_mask);
      end
      `RSA_OP_SETB: begin
        res = `RSA_ALL_ONES;
        to_mem = 1'b1;
      end
      `RSA_OP_SETBIT: begin
        res = mem_rdata | bit_mask;
        to_mem = 1'b1;
      end
      `RSA_OP_NIB: begin
        res = {mem_rdata[3:0], mem_rdata[7:4]};
        to_mem = 1'b1;
      end
      // nibble exchange into working register, memory and flags kept
      `RSA_OP_NIBA: begin
        res = {mem_rdata[3:0], mem_rdata[7:4]};
        to_work = 1'b1;
      end
      default: begin
        res = mem_rdata;
      end
    endcase
  end

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // an op is taken on any edge outside the dummy cycle, so ops may follow
  // back to back; the slot right after a skip is dropped with no answer,
  // which stands for the discarded prefetch of the core
  wire take;
  assign take = exec_valid && !busy;

  // ----------------------------------------
  // arithmetic flag values
  // ----------------------------------------
  reg next_c_sum;
  reg next_ac;
  reg next_z;
  reg next_ov;

  // flag meaning
  // carry out of bit 7 is the inverted borrow, so set means no borrow;
  // overflow when both addends share a sign that the sum lacks
  always @* begin
    next_c_sum = full_sum[8];
    next_ac = low_sum[4];
    next_z = (full_sum[7:0] == 8'h00);
    next_ov = (working_register[7] == sub_b[7]) && (full_sum[7] != working_register[7]);
  end

  // ----------------------------------------
  // working register
  // ----------------------------------------
  // working register load
  // only ops that target the register load it; memory-side ops leave it
  always @(posedge clk_sys) begin
    if (!rstn) begin
      working_register <= `RSA_WORK_RST;
    end else if (take && to_work) begin
      working_register <= res;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // no op asks for both carry sources; the arithmetic one is listed last
  // so it would win if a later code ever did
  always @(posedge clk_sys) begin
    if (!rstn) begin
      flag_c <= `RSA_FLAG_RST;
      flag_ac <= `RSA_FLAG_RST;
      flag_z <= `RSA_FLAG_RST;
      flag_ov <= `RSA_FLAG_RST;
    end else if (take) begin
      if (set_c) begin
        flag_c <= next_c;
      end
      if (arith) begin
        flag_c <= next_c_sum;
        flag_ac <= next_ac;
        flag_z <= next_z;
        flag_ov <= next_ov;
      end
    end
  end

  // ----------------------------------------
  // memory write port
  // ----------------------------------------
  // write back strobe
  // write data keeps its last value; only the strobe marks a write, so
  // the memory side must never latch on a data change alone
  always @(posedge clk_sys) begin
    if (!rstn) begin
      mem_we <= 1'b0;
      mem_wdata <= `RSA_WDATA_RST;
    end else begin
      mem_we <= take && to_mem;
      if (take && to_mem) begin
        mem_wdata <= res;
      end
    end
  end

  // ----------------------------------------
  // skip pipeline
  // ----------------------------------------
  // skip dummy cycle
  // busy stands one clock, making a skipping op two cycles long; the
  // discard pulse tells the fetch side to drop its prefetched word
  always @(posedge clk_sys) begin
    if (!rstn) begin
      skip_discard <= 1'b0;
      busy <= 1'b0;
    end else begin
      skip_discard <= take && skip_hit;
      busy <= take && skip_hit;
    end
  end

endmodule // rsa_alu

/* File: tb/rsa_alu_sva.sv */
`timescale 1ns/1ps
`include "rsa_alu_map.vh"
// ----------------------------------------
// checker on the datapath ports
// ----------------------------------------
module rsa_alu_sva (
  input wire clk_sys,
  input wire rstn,
  input wire exec_valid,
  input wire [4:0] exec_op,
  input wire [7:0] mem_rdata,
  input wire [7:0] imm_data,
  input wire [2:0] bit_sel,
  input wire [7:0] working_register,
  input wire flag_c,
  input wire flag_ac,
  input wire flag_z,
  input wire flag_ov,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  input wire skip_discard,
  input wire busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // request taken only outside the dummy cycle
  wire go = exec_valid && !busy;
  // dummy cycle, then nothing done for the refused slot
  sequence s_dummy;
    busy ##1 (!busy && !mem_we && !skip_discard);
  endsequence
  a_skip_dummy_cycle: assert property (skip_discard |-> s_dummy)
    else $error("skip dummy cycle wrong");
  a_dec_skip_zero: assert property (go && exec_op == `RSA_OP_DSZ && mem_rdata == 8'h01
    |=> skip_discard && mem_we && mem_wdata == 8'h00) else $error("dec skip wrong");
  a_inc_work_skip: assert property (go && exec_op == `RSA_OP_ISZA && mem_rdata == 8'hFF
    |=> skip_discard && !mem_we && working_register == 8'h00) else $error("inc skip wrong");
  a_rotl_carry_in: assert property (go && exec_op == `RSA_OP_ROT_LEFT_C
    |=> mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(flag_c)}
    && flag_c == $past(mem_rdata[7]))
    else $error("rotate left carry wrong");
  a_rotr_flags_kept: assert property (go && exec_op == `RSA_OP_ROT_RIGHT
    |=> $stable({flag_c, flag_ac, flag_z, flag_ov}) && mem_wdata[7] == $past(mem_rdata[0]))
    else $error("rotate right wrong");
  a_sub_no_borrow: assert property (go && exec_op == `RSA_OP_SUB
    |=> flag_c == ($past(working_register) >= $past(mem_rdata))) else $error("sub carry wrong");
  a_set_all_ones: assert property (go && exec_op == `RSA_OP_SETB
    |=> mem_we && mem_wdata == 8'hFF) else $error("set byte wrong");
  a_bit_test_skip: assert property (go && exec_op == `RSA_OP_BTS
    |=> !mem_we && skip_discard == $past(mem_rdata[bit_sel])) else $error("bit test wrong");
endmodule // rsa_alu_sva

bind rsa_alu rsa_alu_sva chk_i (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .exec_valid(exec_valid),
  .exec_op(exec_op),
  .mem_rdata(mem_rdata),
  .imm_data(imm_data),
  .bit_sel(bit_sel),
  .working_register(working_register),
  .flag_c(flag_c),
  .flag_ac(flag_ac),
  .flag_z(flag_z),
  .flag_ov(flag_ov),
  .mem_we(mem_we),
  .mem_wdata(mem_wdata),
  .skip_discard(skip_discard),
  .busy(busy)
);

/* File: tb/rsa_alu_tb.sv */
`timescale 1ns/1ps
`include "rsa_alu_map.vh"
module rsa_alu_tb;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg exec_valid = 1'b0;
  reg [4:0] exec_op = 5'h00;
  reg [7:0] mem_rdata = 8'h00;
  reg [7:0] imm_data = 8'h00;
  reg [2:0] bit_sel = 3'h0;
  wire [7:0] working_register, mem_wdata;
  wire flag_c, flag_ac, flag_z, flag_ov, mem_we, skip_discard, busy;
  // one word: work reg, flags c/ac/z/ov, write data, busy, write strobe, skip
  wire [23:0] obs = {working_register, flag_c, flag_ac, flag_z, flag_ov, mem_wdata,
    1'b0, busy, mem_we, skip_discard};
  integer err_total = 0;
  integer n_compared = 0;
  integer cyc = 0;
  always #10 clk_sys = ~clk_sys;
  // immediate has its own lane so a mix-up with the memory byte shows
  rsa_alu uut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .exec_valid(exec_valid),
    .exec_op(exec_op),
    .mem_rdata(mem_rdata),
    .imm_data(imm_data),
    .bit_sel(bit_sel),
    .working_register(working_register),
    .flag_c(flag_c),
    .flag_ac(flag_ac),
    .flag_z(flag_z),
    .flag_ov(flag_ov),
    .mem_we(mem_we),
    .mem_wdata(mem_wdata),
    .skip_discard(skip_discard),
    .busy(busy)
  );
  task chk(input [23:0] s, input [23:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("BAD %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  // one op, then an idle slot so a dummy cycle always passes
  task go(input [4:0] o, input [7:0] m, input [7:0] i, input [2:0] b, input [23:0] e);
    begin
      @(posedge clk_sys);
      exec_valid <= 1'b1;
      exec_op <= o;
      mem_rdata <= m;
      imm_data <= i;
      bit_sel <= b;
      @(posedge clk_sys);
      exec_valid <= 1'b0;
      #1 chk(obs, e);
      $display("op %h done", o);
    end
  endtask
  // a second op offered on the very next edge: refused after a skip
  task pair(input [4:0] o, input [7:0] m, input [4:0] o2, input [7:0] m2,
    input [23:0] e1, input [23:0] e2);
    begin
      @(posedge clk_sys);
      exec_valid <= 1'b1;
      exec_op <= o;
      mem_rdata <= m;
      @(posedge clk_sys);
      exec_op <= o2;
      mem_rdata <= m2;
      #1 chk(obs, e1);
      @(posedge clk_sys);
      exec_valid <= 1'b0;
      #1 chk(obs, e2);
      $display("pair %h %h done", o, o2);
    end
  endtask
  task summarize;
    begin
      $display("compared %0d bad %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // hang guard, tests need well under a hundred cycles
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 400) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    #1 chk(obs, 24'h000000);
    go(`RSA_OP_ROT_RIGHT_WORK, 8'h0A, 8'h00, 3'h0, 24'h050000);
    go(`RSA_OP_SUB, 8'h03, 8'h00, 3'h0, 24'h02C000);
    go(`RSA_OP_SUBI, 8'h55, 8'h03, 3'h0, 24'hFF0000);
    go(`RSA_OP_DIFF_BORROW, 8'h7F, 8'h00, 3'h0, 24'h7F9000);
    go(`RSA_OP_DIFF_BORROW_MEM, 8'h01, 8'h00, 3'h0, 24'h7FC7E2);
    go(`RSA_OP_DIFF_MEM, 8'h7F, 8'h00, 3'h0, 24'h7FE002);
    go(`RSA_OP_ROT_LEFT_C, 8'h80, 8'h00, 3'h0, 24'h7FE012);
    go(`RSA_OP_ROT_LEFT_C_WORK, 8'h01, 8'h00, 3'h0, 24'h036010);
    go(`RSA_OP_ROT_RIGHT, 8'h01, 8'h00, 3'h0, 24'h036802);
    go(`RSA_OP_ROT_RIGHT_C, 8'h01, 8'h00, 3'h0, 24'h03E002);
    go(`RSA_OP_ROT_RIGHT_C_WORK, 8'h02, 8'h00, 3'h0, 24'h816000);
    go(`RSA_OP_DSZ, 8'h01, 8'h00, 3'h0, 24'h816007);
    go(`RSA_OP_DSZA, 8'h02, 8'h00, 3'h0, 24'h016000);
    go(`RSA_OP_ISZ, 8'hFF, 8'h00, 3'h0, 24'h016007);
    go(`RSA_OP_ISZA, 8'hFF, 8'h00, 3'h0, 24'h006005);
    go(`RSA_OP_BTS, 8'h08, 8'h00, 3'h3, 24'h006005);
    go(`RSA_OP_BTS, 8'h08, 8'h00, 3'h2, 24'h006000);
    go(`RSA_OP_SETB, 8'h12, 8'h00, 3'h0, 24'h006FF2);
    go(`RSA_OP_SETBIT, 8'h00, 8'h00, 3'h5, 24'h006202);
    go(`RSA_OP_NIB, 8'h3C, 8'h00, 3'h0, 24'h006C32);
    // exchange into the working register, then an unknown code doing nothing
    go(`RSA_OP_NIBA, 8'h3C, 8'h00, 3'h0, 24'hC36C30);
    go(5'h1F, 8'hFF, 8'hFF, 3'h7, 24'hC36C30);
    pair(`RSA_OP_DSZ, 8'h01, `RSA_OP_SETB, 8'h12, 24'hC36007, 24'hC36000);
    pair(`RSA_OP_DSZ, 8'h05, `RSA_OP_SETB, 8'h12, 24'hC36042, 24'hC36FF2);
    // reset again in mid-run: all back to zero, first op right after
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    #1 chk(obs, 24'h000000);
    $display("mid reset done");
    go(`RSA_OP_ROT_LEFT_C, 8'h80, 8'h00, 3'h0, 24'h008002);
    go(`RSA_OP_SUB, 8'h01, 8'h00, 3'h0, 24'hFF0000);
    summarize;
  end
endmodule // rsa_alu_tb
